// ===== verilog/ahp_host_port.sv
// ahp_host_port: byte-wide host bus port of a stereo codec
// assumes: host strobes, selects and data are asynchronous to sys_clk_i;
// the pad ring resolves data_o/data_oe_o with data_i into one bus
//
// Contract
// - capture request goes high while any captured sample waits.
// - capture request stays high until the capture fifo is empty.
// - a read with capture acknowledge low is a dma read of the capture fifo.
// - playback request goes high while the playback fifo can take data.
// - playback request stays high until the playback fifo is full.
// - a write with playback acknowledge low is a dma write into the playback fifo.
// - the two select inputs pick the direct register of a pio access.
// - a read strobe starts a read returning a pio register or a dma sample.
// - a write strobe starts a write into a pio register or a dma sample.
// - pio strobes are ignored unless chip select is low.
// - chip select is disregarded during acknowledged dma cycles.
// - bus driver enable rests high and goes low for a qualified strobe.
// - transceiver direction is high for host-to-device and rests high.
// - transceiver direction goes low only for a qualified read strobe.
// - all bytes move over one eight-bit bidirectional data bus.

`timescale 1ns/1ps

module ahp_host_port
  import ahp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // host bus strobes and selects
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic cs_n_i,
  input wire logic [SEL_W-1:0] direct_reg_select_i,
  input wire logic capture_ack_n_i,
  input wire logic playback_ack_n_i,
  // host data bus
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_o,
  // dma requests and transceiver control
  output logic capture_request_o,
  output logic playback_request_o,
  output logic bus_driver_enable_n_o,
  output logic transceiver_direction_o,
  // core capture stream
  input wire logic cap_valid_i,
  input wire logic [DATA_W-1:0] cap_data_i,
  output logic cap_ready_o,
  // core playback stream
  output logic pb_valid_o,
  output logic [DATA_W-1:0] pb_data_o,
  input wire logic pb_ready_i,
  // direct register access toward the core
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [SEL_W-1:0] reg_sel_o,
  output logic [DATA_W-1:0] reg_wdata_o,
  input wire logic [DATA_W-1:0] reg_rdata_i
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] pin_raw, sync_a, sync_b;
  logic s_rd_n, s_wr_n, s_cs_n, s_cack_n, s_pack_n;
  logic [SEL_W-1:0] s_sel;
  logic [DATA_W-1:0] s_data;

  assign pin_raw = {data_i, direct_reg_select_i, playback_ack_n_i,
                    capture_ack_n_i, cs_n_i, wr_n_i, rd_n_i};

  // strobes sit idle high at reset so no false cycle starts
  for (genvar i = 0; i < SYNC_W; i++)
  begin : g_sync
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
      if (!arst_n_i)
      begin
        sync_a[i] <= SYNC_RST[i];
        sync_b[i] <= SYNC_RST[i];
      end
      else
      begin
        sync_a[i] <= pin_raw[i];
        sync_b[i] <= sync_a[i];
      end
    end
  end

  assign s_rd_n = sync_b[POS_RD_N];
  assign s_wr_n = sync_b[POS_WR_N];
  assign s_cs_n = sync_b[POS_CS_N];
  assign s_cack_n = sync_b[POS_CACK_N];
  assign s_pack_n = sync_b[POS_PACK_N];
  assign s_sel = sync_b[POS_SEL +: SEL_W];
  assign s_data = sync_b[POS_DATA +: DATA_W];

  // ---------------------------------------------------------------
  // fifos
  // ---------------------------------------------------------------
  logic cap_pop, cap_out_valid, pb_push, pb_in_ready;
  logic [DATA_W-1:0] cap_head;
  logic [DATA_W-1:0] wdata, next_wdata;

  ahp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_cap_fifo (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(cap_valid_i),
    .in_data_i(cap_data_i),
    .in_ready_o(cap_ready_o),
    .out_valid_o(cap_out_valid),
    .out_data_o(cap_head),
    .out_ready_i(cap_pop)
  );

  // a host write into a full fifo is lost; the low request warned it off
  ahp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_pb_fifo (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(pb_push),
    .in_data_i(wdata),
    .in_ready_o(pb_in_ready),
    .out_valid_o(pb_valid_o),
    .out_data_o(pb_data_o),
    .out_ready_i(pb_ready_i)
  );

  // ---------------------------------------------------------------
  // cycle tracker
  // ---------------------------------------------------------------
  ahp_state_type state, next_state;
  logic [SEL_W-1:0] sel, next_sel;
  logic next_reg_wr, next_reg_rd;
  logic [DATA_W-1:0] next_data;
  logic next_oe, next_bus_driver_enable_n_n, next_dir;
  logic ack_any, strobe_qual, read_qual;

  always_comb
  begin
    next_state = state;
    next_sel = sel;
    next_wdata = wdata;
    next_reg_wr = 1'b0;
    next_reg_rd = 1'b0;
    cap_pop = 1'b0;
    pb_push = 1'b0;
    unique case (state)
      ST_IDLE:
      begin
        if (!s_rd_n)
        begin
          if (!s_cack_n)
          begin
            next_state = ST_CAP_RD;
          end
          else if (!s_pack_n)
          begin
            next_state = ST_DMA_IGN;
          end
          else if (!s_cs_n)
          begin
            next_state = ST_PIO_RD;
            next_sel = s_sel;
          end
        end
        else if (!s_wr_n)
        begin
          if (!s_pack_n)
          begin
            next_state = ST_PB_WR;
          end
          else if (!s_cack_n)
          begin
            next_state = ST_DMA_IGN;
          end
          else if (!s_cs_n)
          begin
            next_state = ST_PIO_WR;
            next_sel = s_sel;
          end
        end
      end
      ST_PIO_RD, ST_CAP_RD:
      begin
        if (s_rd_n)
        begin
          next_state = ST_IDLE;
          next_reg_rd = (state == ST_PIO_RD);
          cap_pop = (state == ST_CAP_RD) && cap_out_valid;
        end
      end
      ST_PIO_WR, ST_PB_WR:
      begin
        // data is taken from the cycle before the strobe was seen high
        if (s_wr_n)
        begin
          next_state = ST_IDLE;
          next_reg_wr = (state == ST_PIO_WR);
          pb_push = (state == ST_PB_WR);
        end
        else
        begin
          next_wdata = s_data;
        end
      end
      ST_DMA_IGN:
      begin
        if (s_rd_n && s_wr_n)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state <= ST_IDLE;
      sel <= SEL_RST;
      wdata <= DATA_RST;
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      reg_sel_o <= SEL_RST;
      reg_wdata_o <= DATA_RST;
    end
    else
    begin
      state <= next_state;
      sel <= next_sel;
      wdata <= next_wdata;
      reg_wr_o <= next_reg_wr;
      reg_rd_o <= next_reg_rd;
      reg_sel_o <= next_sel;
      reg_wdata_o <= next_wdata;
    end
  end

  // ---------------------------------------------------------------
  // pin outputs
  // ---------------------------------------------------------------
  // registered after the synchroniser, so these trail the pins by a few clocks
  always_comb
  begin
    ack_any = !s_cack_n || !s_pack_n;
    strobe_qual = (!s_rd_n || !s_wr_n) && (!s_cs_n || ack_any);
    read_qual = !s_rd_n && (!s_cs_n || ack_any);
    next_bus_driver_enable_n_n = !strobe_qual;
    next_dir = !read_qual;
    next_oe = (next_state == ST_PIO_RD) || (next_state == ST_CAP_RD);
    next_data = DATA_RST;
    if (next_state == ST_CAP_RD)
    begin
      next_data = cap_head;
    end
    else if (next_state == ST_PIO_RD)
    begin
      next_data = reg_rdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      capture_request_o <= 1'b0;
      playback_request_o <= 1'b0;
      bus_driver_enable_n_o <= 1'b1;
      transceiver_direction_o <= 1'b1;
      data_oe_o <= 1'b0;
      data_o <= DATA_RST;
    end
    else
    begin
      capture_request_o <= cap_out_valid;
      playback_request_o <= pb_in_ready;
      bus_driver_enable_n_o <= next_bus_driver_enable_n_n;
      transceiver_direction_o <= next_dir;
      data_oe_o <= next_oe;
      data_o <= next_data;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_cap_req_raise: assert property (cap_out_valid |=> capture_request_o)
    else $error("capture request not raised for waiting sample");
  a_cap_req_empty: assert property (!cap_out_valid |=> !capture_request_o)
    else $error("capture request high with empty capture fifo");
  a_cap_rd_start: assert property (state == ST_IDLE && !s_rd_n && !s_cack_n
    |=> state == ST_CAP_RD && data_oe_o && data_o == $past(cap_head))
    else $error("acknowledged read not served from capture fifo");
  a_pb_req_room: assert property (pb_in_ready |=> playback_request_o)
    else $error("playback request low with room in fifo");
  a_pb_req_full: assert property (!pb_in_ready |=> !playback_request_o)
    else $error("playback request high with full fifo");
  a_pb_push_end: assert property (state == ST_PB_WR && !s_wr_n ##1 s_wr_n
    |-> pb_push && wdata == $past(s_data))
    else $error("dma write byte not pushed into playback fifo");
  a_reg_wr_sel: assert property (reg_wr_o
    |-> $past(state) == ST_PIO_WR && reg_sel_o == $past(sel) && state == ST_IDLE)
    else $error("register write without matching pio cycle");
  a_pio_rd_data: assert property (state == ST_PIO_RD && !s_rd_n
    |=> data_o == $past(reg_rdata_i) && data_oe_o)
    else $error("pio read data not presented");
  a_pio_ignored: assert property (state == ST_IDLE && s_cs_n && s_cack_n && s_pack_n
    |=> state == ST_IDLE)
    else $error("strobe taken without chip select or acknowledge");
  a_dma_no_cs: assert property (state == ST_IDLE && !s_wr_n && !s_pack_n && s_cs_n
    && s_rd_n |=> state == ST_PB_WR)
    else $error("dma write depended on chip select");
  a_bus_driver_enable_n_track: assert property (strobe_qual |=> !bus_driver_enable_n_o ##1
    (bus_driver_enable_n_o == !$past(strobe_qual)))
    else $error("bus driver enable does not follow qualified strobe");
  a_dir_rest: assert property (!read_qual |=> transceiver_direction_o)
    else $error("transceiver direction low without qualified read");
  a_dir_read: assert property (read_qual |=> !transceiver_direction_o)
    else $error("transceiver direction high during qualified read");
  a_oe_only_rd: assert property (data_oe_o |-> state == ST_PIO_RD || state == ST_CAP_RD)
    else $error("data bus driven outside a read cycle");

  c_cap_dma: cover property (state == ST_CAP_RD ##[1:20] cap_pop);
  c_pb_dma: cover property (state == ST_PB_WR ##[1:20] pb_push);
  c_pio_wr: cover property (reg_wr_o);
  c_pio_rd: cover property (state == ST_PIO_RD ##[1:20] reg_rd_o);

endmodule // ahp_host_port

// ===== verilog/ahp_pkg.sv
// ahp_pkg: shared constants of the codec host port
// assumes: one 10 MHz system clock; host bus pins arrive asynchronously

package ahp_pkg;

  // ---------------------------------------------------------------
  // widths and depths
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int SEL_W = 2;
  localparam int FIFO_DEPTH = 8;

  // ---------------------------------------------------------------
  // synchroniser vector layout
  // ---------------------------------------------------------------
  localparam int SYNC_W = 15;
  localparam int POS_RD_N = 0;
  localparam int POS_WR_N = 1;
  localparam int POS_CS_N = 2;
  localparam int POS_CACK_N = 3;
  localparam int POS_PACK_N = 4;
  localparam int POS_SEL = 5;
  localparam int POS_DATA = 7;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [SYNC_W-1:0] SYNC_RST = 15'h001f;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [SEL_W-1:0] SEL_RST = 2'h0;

  // ---------------------------------------------------------------
  // cycle tracker states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PIO_RD = 3'b001,
    ST_PIO_WR = 3'b010,
    ST_CAP_RD = 3'b011,
    ST_PB_WR = 3'b100,
    ST_DMA_IGN = 3'b101
  } ahp_state_type;

endpackage

// ===== verilog/ahp_fifo.sv
// ahp_fifo: synchronous fifo with valid/ready on both sides
// assumes: both sides on sys_clk_i; flags are registered

`timescale 1ns/1ps

module ahp_fifo
  import ahp_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wptr, next_wptr, rptr, next_rptr;
  logic [CW-1:0] count, next_count;
  logic next_in_ready, next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic push, pop;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // flags are registered so both handshakes come straight from flops
  always_comb
  begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    next_wptr = wptr;
    next_rptr = rptr;
    next_count = count;
    if (push)
    begin
      next_wptr = (wptr == PW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
    end
    if (pop)
    begin
      next_rptr = (rptr == PW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_count = count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_count = count - 1'b1;
    end
    next_in_ready = (next_count != CW'(DEPTH));
    next_out_valid = (next_count != '0);
    // head is registered; a byte landing in the slot about to show bypasses storage
    next_out_data = mem[next_rptr];
    if (push && (wptr == next_rptr))
    begin
      next_out_data = in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end
    else
    begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
      in_ready_o <= next_in_ready;
      out_valid_o <= next_out_valid;
      out_data_o <= next_out_data;
    end
  end

  // storage needs no reset; only entries behind the count are read
  always_ff @(posedge sys_clk_i)
  begin
    if (push)
    begin
      mem[wptr] <= in_data_i;
    end
  end

endmodule // ahp_fifo

// ===== tb/ahp_host_model.sv
// ahp_host_model: host bus with dma controller facing the codec host port
// assumes: driven from the bench by bus_cycle; one cycle at a time

`timescale 1ns/1ps

module ahp_host_model
  import ahp_pkg::*;
(
  // clock
  input wire logic sys_clk_i,
  // device side of the bus
  input wire logic [DATA_W-1:0] data_o_i,
  input wire logic data_oe_i,
  input wire logic bus_driver_enable_n_i,
  input wire logic transceiver_direction_i,
  // host strobes and selects
  output logic rd_n_o,
  output logic wr_n_o,
  output logic cs_n_o,
  output logic capture_ack_n_o,
  output logic playback_ack_n_o,
  output logic [SEL_W-1:0] direct_reg_select_o,
  // resolved data bus
  output logic [DATA_W-1:0] bus_o
);
  logic host_drv;
  logic cross_ack;
  logic [DATA_W-1:0] host_data;
  logic [DATA_W-1:0] idle_pattern;

  initial
  begin
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    cs_n_o = 1'b1;
    capture_ack_n_o = 1'b1;
    playback_ack_n_o = 1'b1;
    direct_reg_select_o = 2'h0;
    host_drv = 1'b0;
    cross_ack = 1'b0;
    host_data = 8'h00;
    idle_pattern = 8'h5a;
  end

  // released bus moves every cycle so a stale byte never passes for a good one
  always @(posedge sys_clk_i) idle_pattern <= idle_pattern + 8'h35;
  assign bus_o = data_oe_i ? data_o_i : (host_drv ? host_data : idle_pattern);

  // ---------------------------------------------------------------
  // one host access: setup, strobe held 5 cycles, hold, 6 idle cycles
  // ---------------------------------------------------------------
  task automatic bus_cycle(
    input logic rd, input logic cs_n, input logic ack_n, input logic [SEL_W-1:0] sel,
    input logic [DATA_W-1:0] wdata, output logic [DATA_W-1:0] rdata,
    output logic bus_driver_enable_n_n, output logic dir, output logic oe);
    @(posedge sys_clk_i);
    #10;
    cs_n_o = cs_n;
    direct_reg_select_o = sel;
    capture_ack_n_o = (rd ^ cross_ack) ? ack_n : 1'b1;
    playback_ack_n_o = (rd ^ cross_ack) ? 1'b1 : ack_n;
    host_data = wdata;
    host_drv = !rd;
    @(posedge sys_clk_i);
    #10;
    rd_n_o = !rd;
    wr_n_o = rd;
    repeat (5) @(posedge sys_clk_i);
    #10;
    rdata = bus_o;
    bus_driver_enable_n_n = bus_driver_enable_n_i;
    dir = transceiver_direction_i;
    oe = data_oe_i;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    @(posedge sys_clk_i);
    #10;
    cs_n_o = 1'b1;
    capture_ack_n_o = 1'b1;
    playback_ack_n_o = 1'b1;
    host_drv = 1'b0;
    repeat (6) @(posedge sys_clk_i);
    #10;
  endtask

  // route the acknowledge to the channel opposite the strobe
  task automatic set_cross(input logic v);
    cross_ack = v;
  endtask
endmodule // ahp_host_model

// ===== tb/ahp_host_port_tb.sv
// ahp_host_port_tb: self-checking bench of the codec host port
// assumes: host model drives the bus; the bench plays the codec core

`timescale 1ns/1ps

module ahp_host_port_tb;
  import ahp_pkg::*;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic rd_n, wr_n, cs_n, cack_n, pack_n, data_oe, cap_req, pb_req, bus_driver_enable_n_n, dir;
  logic cap_valid = 1'b0, cap_ready, pb_valid, pb_ready = 1'b0, reg_wr, reg_rd;
  logic [SEL_W-1:0] sel, reg_sel;
  logic [DATA_W-1:0] bus, data_o, cap_data = 8'h00, pb_data, reg_wdata, reg_rdata = 8'h00;
  logic [DATA_W-1:0] rdata, wd;
  logic b_bus_driver_enable_n, b_dir, b_oe;
  logic [7:0] cap_q[$], pb_q[$], pb_log[$];
  logic [9:0] wr_exp[$], wr_log[$];
  logic [1:0] rd_log[$];
  int err_total = 0;
  int checks_done = 0;
  int seed = 11;

  always #50 sys_clk_i = ~sys_clk_i;

  ahp_host_port dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .cs_n_i(cs_n), .direct_reg_select_i(sel), .capture_ack_n_i(cack_n),
    .playback_ack_n_i(pack_n), .data_i(bus), .data_o(data_o), .data_oe_o(data_oe),
    .capture_request_o(cap_req), .playback_request_o(pb_req),
    .bus_driver_enable_n_o(bus_driver_enable_n_n), .transceiver_direction_o(dir),
    .cap_valid_i(cap_valid), .cap_data_i(cap_data), .cap_ready_o(cap_ready),
    .pb_valid_o(pb_valid), .pb_data_o(pb_data), .pb_ready_i(pb_ready),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_sel_o(reg_sel),
    .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));

  ahp_host_model host (.sys_clk_i(sys_clk_i), .data_o_i(data_o), .data_oe_i(data_oe),
    .bus_driver_enable_n_i(bus_driver_enable_n_n), .transceiver_direction_i(dir), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .cs_n_o(cs_n), .capture_ack_n_o(cack_n), .playback_ack_n_o(pack_n),
    .direct_reg_select_o(sel), .bus_o(bus));

  // ---------------------------------------------------------------
  // observed core-side transfers
  // ---------------------------------------------------------------
  always @(posedge sys_clk_i)
  begin
    if (cap_valid === 1'b1 && cap_ready === 1'b1) cap_q.push_back(cap_data);
    if (pb_valid === 1'b1 && pb_ready === 1'b1) pb_log.push_back(pb_data);
    if (reg_wr === 1'b1) wr_log.push_back({reg_sel, reg_wdata});
    if (reg_rd === 1'b1) rd_log.push_back(reg_sel);
  end

  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 2000 cycles
  initial
  begin
    repeat (6000) @(posedge sys_clk_i);
    err_total++;
    complete_run();
  end

  initial
  begin
    repeat (20) @(posedge sys_clk_i);
    check(10'({bus_driver_enable_n_n, dir, data_oe, cap_req}), 10'h00c);
    #10;
    arst_n_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #10;
    check(10'({bus_driver_enable_n_n, dir, data_oe, pb_req}), 10'h00d);
    // fill the capture fifo until it refuses
    cap_valid = 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      cap_data = 8'($random(seed));
      @(posedge sys_clk_i);
      #10;
    end
    cap_valid = 1'b0;
    check(10'(cap_q.size()), 10'(FIFO_DEPTH));
    check(10'({cap_ready, cap_req}), 10'h001);
    // drain it by dma reads; chip select toggles and must not matter
    for (int i = 0; i < FIFO_DEPTH; i++)
    begin
      host.bus_cycle(1'b1, 1'(i), 1'b0, 2'(i), 8'h00, rdata, b_bus_driver_enable_n, b_dir, b_oe);
      check(10'(rdata), 10'(cap_q.pop_front()));
      check(10'({b_bus_driver_enable_n, b_dir, b_oe}), 10'h001);
      check(10'(cap_req), 10'(i < FIFO_DEPTH - 1));
    end
    // playback writes with the core stalled; the ninth is dropped
    for (int i = 0; i <= FIFO_DEPTH; i++)
    begin
      wd = 8'($random(seed));
      if (i < FIFO_DEPTH) pb_q.push_back(wd);
      host.bus_cycle(1'b0, 1'(~i), 1'b0, 2'(i), wd, rdata, b_bus_driver_enable_n, b_dir, b_oe);
      check(10'({b_bus_driver_enable_n, b_dir, b_oe}), 10'h002);
      check(10'(pb_req), 10'(i < FIFO_DEPTH - 1));
    end
    check(10'(wr_log.size()), 10'h000);
    pb_ready = 1'b1;
    repeat (20) @(posedge sys_clk_i);
    #10;
    check(10'({pb_valid, pb_req}), 10'h001);
    check(10'(pb_log.size()), 10'(pb_q.size()));
    foreach (pb_q[i]) check(10'(pb_log[i]), 10'(pb_q[i]));
    // pio writes and reads over every select code
    for (int s = 0; s < 4; s++)
    begin
      wd = 8'($random(seed));
      wr_exp.push_back({2'(s), wd});
      host.bus_cycle(1'b0, 1'b0, 1'b1, 2'(s), wd, rdata, b_bus_driver_enable_n, b_dir, b_oe);
      check(10'({b_bus_driver_enable_n, b_dir, b_oe}), 10'h002);
      reg_rdata = 8'($random(seed));
      host.bus_cycle(1'b1, 1'b0, 1'b1, 2'(s), 8'h00, rdata, b_bus_driver_enable_n, b_dir, b_oe);
      check(10'(rdata), 10'(reg_rdata));
      check(10'({b_bus_driver_enable_n, b_dir, b_oe}), 10'h001);
      check(10'(rd_log.size() > s ? rd_log[s] : 2'h3 ^ 2'(s)), 10'(s));
    end
    check(10'(wr_log.size()), 10'h004);
    foreach (wr_exp[i]) check(wr_log[i], wr_exp[i]);
    // strobes without chip select or acknowledge are ignored
    host.bus_cycle(1'b0, 1'b1, 1'b1, 2'h1, 8'ha5, rdata, b_bus_driver_enable_n, b_dir, b_oe);
    check(10'({b_bus_driver_enable_n, b_dir, b_oe}), 10'h006);
    host.bus_cycle(1'b1, 1'b1, 1'b1, 2'h2, 8'h00, rdata, b_bus_driver_enable_n, b_dir, b_oe);
    check(10'({b_bus_driver_enable_n, b_dir, b_oe}), 10'h006);
    // acknowledge with the opposite strobe moves nothing but still turns the drivers
    host.set_cross(1'b1);
    host.bus_cycle(1'b0, 1'b1, 1'b0, 2'h0, 8'h3c, rdata, b_bus_driver_enable_n, b_dir, b_oe);
    check(10'({b_bus_driver_enable_n, b_dir, b_oe}), 10'h002);
    host.bus_cycle(1'b1, 1'b1, 1'b0, 2'h3, 8'h00, rdata, b_bus_driver_enable_n, b_dir, b_oe);
    check(10'({b_bus_driver_enable_n, b_dir, b_oe}), 10'h000);
    host.set_cross(1'b0);
    check(10'(pb_log.size()), 10'(pb_q.size()));
    check(10'({wr_log.size() == 4, rd_log.size() == 4}), 10'h003);
    complete_run();
  end
endmodule // ahp_host_port_tb
